// >>> design/lsif_top.sv
// Purpose: Link status and interrupt flags with AXI4-Lite registers
// Assumes: Frame engine supplies one-cycle event pulses and levels
`timescale 1ns/10ps
`default_nettype none
`include "lsif_params.svh"
module lsif_top #(
  parameter int ERR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic uart_mode,
  input wire logic [1:0] special_id_code,
  input wire logic special_id_seen,
  input wire logic transfer_active,
  input wire logic [ERR_W-1:0] error_events,
  input wire logic identifier_event,
  input wire logic transmit_done_event,
  input wire logic receive_done_event,
  input wire logic [7:0] frame_rx_data,
  output logic [7:0] frame_tx_data,
  output logic frame_tx_load,
  output logic irq
);
  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  lsif_pkg::lsif_wstate_type wstate_r;
  lsif_pkg::lsif_wstate_type wstate_nxt;
  logic aw_held_r;
  logic [3:0] awaddr_r;
  logic w_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r;
  logic [3:0] interrupt_enable_register_r;
  logic [7:0] frame_tx_data_r;
  logic frame_tx_load_r;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held_r || aw_take;
  wire w_have = w_held_r || w_take;
  wire [3:0] wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata;
  wire [3:0] wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
  wire wr_go = (wstate_r == lsif_pkg::LSIF_W_IDLE) && aw_have && w_have;
  wire wr_lane0 = wr_go && wr_strb[0];
  wire wr_status = wr_lane0 && (wr_addr == `LSIF_OFS_STATUS);
  wire wr_enable = wr_lane0 && (wr_addr == `LSIF_OFS_ENABLE);
  wire wr_data_reg = wr_lane0 && (wr_addr == `LSIF_OFS_DATA);
  wire wr_mapped = (wr_addr == `LSIF_OFS_STATUS) || (wr_addr == `LSIF_OFS_ENABLE) ||
                   (wr_addr == `LSIF_OFS_ERRDET) || (wr_addr == `LSIF_OFS_DATA);
  assign s_axi_awready = (wstate_r == lsif_pkg::LSIF_W_IDLE) && !aw_held_r;
  assign s_axi_wready = (wstate_r == lsif_pkg::LSIF_W_IDLE) && !w_held_r;
  assign s_axi_bvalid = (wstate_r == lsif_pkg::LSIF_W_RESP);
  assign s_axi_bresp = bresp_r;
  always_comb begin
    wstate_nxt = wstate_r;
    case (wstate_r)
      lsif_pkg::LSIF_W_IDLE: begin
        if (wr_go) begin
          wstate_nxt = lsif_pkg::LSIF_W_RESP;
        end
      end
      lsif_pkg::LSIF_W_RESP: begin
        if (s_axi_bready) begin
          wstate_nxt = lsif_pkg::LSIF_W_IDLE;
        end
      end
      default: begin
        wstate_nxt = lsif_pkg::LSIF_W_IDLE;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate_r <= lsif_pkg::LSIF_W_IDLE;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bresp_r <= 2'h0;
    end else begin
      wstate_r <= wstate_nxt;
      aw_held_r <= aw_have && !wr_go;
      w_held_r <= w_have && !wr_go;
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        bresp_r <= wr_mapped ? 2'h0 : 2'h2;
      end
    end
  end
  // ----------------------------------------------------------------
  // Enable and transmit data registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_enable_register_r <= `LSIF_RST_ENABLE;
      frame_tx_data_r <= `LSIF_RST_DATA;
      frame_tx_load_r <= 1'b0;
    end else begin
      if (wr_enable) begin
        interrupt_enable_register_r <= wr_data[3:0];
      end
      if (wr_data_reg) begin
        frame_tx_data_r <= wr_data[7:0];
      end
      frame_tx_load_r <= wr_data_reg;
    end
  end
  assign frame_tx_data = frame_tx_data_r;
  assign frame_tx_load = frame_tx_load_r;
  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire rd_data_reg = rd_take && (s_axi_araddr == `LSIF_OFS_DATA);
  logic [7:0] status_word;
  logic [ERR_W-1:0] error_detail_register;
  wire rd_status = (s_axi_araddr == `LSIF_OFS_STATUS);
  wire rd_enable = (s_axi_araddr == `LSIF_OFS_ENABLE);
  wire rd_errdet = (s_axi_araddr == `LSIF_OFS_ERRDET);
  wire rd_mapped = rd_status || rd_enable || rd_errdet || (s_axi_araddr == `LSIF_OFS_DATA);
  wire [31:0] rd_word = rd_status ? {24'h000000, status_word} :
                        rd_enable ? {28'h0000000, interrupt_enable_register_r} :
                        rd_errdet ? {{(32-ERR_W){1'b0}}, error_detail_register} :
                        rd_mapped ? {24'h000000, frame_rx_data} : 32'h00000000;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= 2'h0;
    end else begin
      if (rd_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= rd_mapped ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  logic identifier_event_flag;
  logic transmit_done_flag;
  logic receive_done_flag;
  logic error_event_flag;
  wire uart_rd = uart_mode && rd_data_reg;
  wire uart_wr = uart_mode && wr_data_reg;
  wire clr_err = (wr_status && wr_data[`LSIF_BIT_ERR]) || uart_rd;
  lsif_errdet #(
    .WIDTH(ERR_W)
  ) u_errdet (
    .aclk(aclk),
    .aresetn(aresetn),
    .err_set(error_events),
    .clr_all(clr_err),
    .det_out(error_detail_register)
  );
  assign error_event_flag = |error_detail_register;
  lsif_flag u_idok (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_in(identifier_event),
    .clr_in(wr_status && wr_data[`LSIF_BIT_IDOK]),
    .flag_out(identifier_event_flag)
  );
  lsif_flag u_txok (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_in(transmit_done_event),
    .clr_in((wr_status && wr_data[`LSIF_BIT_TXOK]) || uart_wr),
    .flag_out(transmit_done_flag)
  );
  lsif_flag u_rxok (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_in(receive_done_event),
    .clr_in((wr_status && wr_data[`LSIF_BIT_RXOK]) || uart_rd),
    .flag_out(receive_done_flag)
  );
  wire [2:0] special_identifier_status = special_id_seen ? {1'b1, special_id_code} : 3'h0;
  wire transfer_active_flag = transfer_active;
  assign status_word = {special_identifier_status, transfer_active_flag, error_event_flag,
                        identifier_event_flag, transmit_done_flag, receive_done_flag};
  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  wire [3:0] irq_pending = status_word[3:0] & interrupt_enable_register_r;
  assign irq = |irq_pending;
endmodule
`default_nettype wire

// >>> design/lsif_params.svh
// Purpose: Offsets, field positions, reset values of the link status block
// Assumes: AXI4-Lite, 32-bit data, one word per register
// Notes: Byte addresses
`ifndef LSIF_PARAMS_SVH
`define LSIF_PARAMS_SVH
`define LSIF_OFS_STATUS 4'h0
`define LSIF_OFS_ENABLE 4'h4
`define LSIF_OFS_ERRDET 4'h8
`define LSIF_OFS_DATA 4'hC
`define LSIF_BIT_IDST_HI 7
`define LSIF_BIT_IDST_LO 5
`define LSIF_BIT_BUSY 4
`define LSIF_BIT_ERR 3
`define LSIF_BIT_IDOK 2
`define LSIF_BIT_TXOK 1
`define LSIF_BIT_RXOK 0
`define LSIF_RST_STATUS 8'h00
`define LSIF_RST_ENABLE 4'h0
`define LSIF_RST_ERRDET 8'h00
`define LSIF_RST_DATA 8'h00
`endif

// >>> design/lsif_pkg.sv
// Purpose: Types of the link status block
// Assumes: Nothing
// Notes: Write channel states
package lsif_pkg;
  typedef enum logic [1:0] {
    LSIF_W_IDLE = 2'b00,
    LSIF_W_RESP = 2'b01
  } lsif_wstate_type;
endpackage

// >>> design/lsif_flag.sv
// Purpose: One sticky event flag, set wins over clear
// Assumes: Synchronous active-low reset
// Notes: None
`timescale 1ns/10ps
`default_nettype none
module lsif_flag (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic set_in,
  input wire logic clr_in,
  output logic flag_out
);
  logic flag_r;
  logic flag_nxt;
  assign flag_nxt = set_in ? 1'b1 : (clr_in ? 1'b0 : flag_r);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end
  assign flag_out = flag_r;
endmodule
`default_nettype wire

// >>> design/lsif_errdet.sv
// Purpose: Error-detail register, sticky bits set by the core
// Assumes: Synchronous active-low reset
// Notes: Whole register cleared at once; a new error beats the clear
`timescale 1ns/10ps
`default_nettype none
module lsif_errdet #(
  parameter int WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] err_set,
  input wire logic clr_all,
  output logic [WIDTH-1:0] det_out
);
  logic [WIDTH-1:0] det_r;
  logic [WIDTH-1:0] det_nxt;
  assign det_nxt = err_set | (clr_all ? {WIDTH{1'b0}} : det_r);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      det_r <= {WIDTH{1'b0}};
    end else begin
      det_r <= det_nxt;
    end
  end
  assign det_out = det_r;
endmodule
`default_nettype wire

// >>> tb/lsif_engine.sv
// Purpose: Frame engine model driving event pulses
// Assumes: Bench raises kick for one cycle
// Notes: Each output is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module lsif_engine (
  input wire logic aclk,
  input wire logic [10:0] kick,
  output logic [7:0] error_events,
  output logic identifier_event,
  output logic transmit_done_event,
  output logic receive_done_event
);
  always_ff @(posedge aclk) begin
    {error_events, identifier_event, transmit_done_event, receive_done_event} <= kick;
  end
endmodule
`default_nettype wire

// >>> tb/lsif_assertions.sv
// Purpose: Port checks of the link status block
// Assumes: Offsets 0x0 status, 0xC frame data
// Notes: Bound from tb_top
`timescale 1ns/10ps
`default_nettype none
module lsif_assertions #(
  parameter int ERR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic uart_mode,
  input wire logic [1:0] special_id_code,
  input wire logic special_id_seen,
  input wire logic transfer_active,
  input wire logic [ERR_W-1:0] error_events,
  input wire logic identifier_event,
  input wire logic transmit_done_event,
  input wire logic receive_done_event,
  input wire logic irq
);
  wire ar0 = s_axi_arvalid & s_axi_arready & (s_axi_araddr == 4'h0);
  wire arc = s_axi_arvalid & s_axi_arready & (s_axi_araddr == 4'hC);
  wire wt = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & s_axi_wstrb[0];
  wire [2:0] idx = special_id_seen ? {1'h1, special_id_code} : 3'h0;
  wire quiet = !transmit_done_event & !receive_done_event & !(|error_events);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_idst; ar0 |=> s_axi_rdata[7:5] == $past(idx); endproperty
  a_idst: assert property (p_idst) else $error("id status wrong");
  property p_busy; ar0 |=> s_axi_rdata[4] == $past(transfer_active); endproperty
  a_busy: assert property (p_busy) else $error("busy bit wrong");
  property p_err; (|error_events) ##1 ar0 |=> s_axi_rdata[3]; endproperty
  a_err: assert property (p_err) else $error("error flag not set");
  property p_idok; identifier_event ##1 ar0 |=> s_axi_rdata[2]; endproperty
  a_idok: assert property (p_idok) else $error("id flag not set");
  property p_txok; transmit_done_event ##1 ar0 |=> s_axi_rdata[1]; endproperty
  a_txok: assert property (p_txok) else $error("tx flag not set");
  property p_rxok; receive_done_event ##1 ar0 |=> s_axi_rdata[0]; endproperty
  a_rxok: assert property (p_rxok) else $error("rx flag not set");
  property p_w1c;
    (wt && s_axi_awaddr == 4'h0 && s_axi_wdata[1] && quiet) ##1 quiet ##1 ar0 |=> !s_axi_rdata[1];
  endproperty
  a_w1c: assert property (p_w1c) else $error("tx flag not cleared");
  property p_rdclr;
    (uart_mode && arc && quiet) ##1 quiet ##1 ar0 |=> !s_axi_rdata[3] && !s_axi_rdata[0];
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("data read no clear");
  property p_wrclr;
    (uart_mode && wt && s_axi_awaddr == 4'hC && quiet) ##1 quiet ##1 ar0 |=> !s_axi_rdata[1];
  endproperty
  a_wrclr: assert property (p_wrclr) else $error("data write no clear");
  property p_rst; $rose(aresetn) |-> !irq; endproperty
  a_rst: assert property (p_rst) else $error("irq after reset");
  c_irq: cover property (irq);
  c_uart: cover property (uart_mode && arc);
  c_w1c: cover property (wt && s_axi_awaddr == 4'h0);
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: Self-checking bench of the link status block
// Assumes: Design takes write address and data together when idle
// Notes: Model state st, det, en mirrors the flags
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h1, uart_mode = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq, frame_tx_load, identifier_event, transmit_done_event, receive_done_event;
  logic [1:0] s_axi_bresp, s_axi_rresp, special_id_code = 2'h0;
  logic special_id_seen = 1'h0, transfer_active = 1'h0;
  logic [7:0] frame_rx_data = 8'h0, frame_tx_data, error_events, det = 8'h0;
  logic [10:0] kick = 11'h0;
  logic [2:0] st = 3'h0;
  logic [3:0] en = 4'h0;
  int n_errors = 0, checked = 0, cyc = 0, i;
  lsif_top DUT (.*);
  lsif_engine u_eng (.*);
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [31:0] mrd(input logic [3:0] a);
    case (a)
      4'h0: return {24'h0, special_id_seen, special_id_seen ? special_id_code : 2'h0,
                    transfer_active, |det, st};
      4'h4: return {28'h0, en};
      4'h8: return {24'h0, det};
      default: return {24'h0, frame_rx_data};
    endcase
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do @(posedge aclk); while (!(s_axi_awready === 1'h1 && s_axi_wready === 1'h1));
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    if (a == 4'h0 && v[3]) det = 8'h0;
    if (a == 4'h0) st = st & ~v[2:0];
    if (a == 4'h4) en = v[3:0];
    if (a == 4'hC && uart_mode) st[1] = 1'h0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    chk("bresp", 32'(s_axi_bresp), (a[1:0] == 2'h0) ? 32'h0 : 32'h2);
    chk("irq", 32'(irq), 32'(|({|det, st} & en)));
  endtask
  task automatic rd(input logic [3:0] a);
    logic [31:0] e;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    e = mrd(a);
    s_axi_arvalid <= 1'h0;
    if (a == 4'hC && uart_mode) {det, st[0]} = 9'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    chk("rresp", 32'(s_axi_rresp), 32'h0);
    chk("rdata", s_axi_rdata, e);
  endtask
  task automatic ev(input logic [10:0] k);
    kick <= k;
    @(posedge aclk);
    kick <= 11'h0;
    @(posedge aclk);
    det = det | k[10:3];
    st = st | k[2:0];
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'hB10358DB));
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (i = 0; i < 16; i += 4) rd(i[3:0]);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      special_id_seen <= i[2];
      special_id_code <= i[1:0];
      transfer_active <= i[0];
      rd(4'h0);
    end
    $display("test status done");
    for (i = 0; i < 14; i++) begin
      wr(4'h4, $urandom);
      ev(i < 11 ? 11'h1 << i : 11'($urandom));
      rd(4'h0);
      wr(4'h0, 32'h0);
      wr(4'h0, 32'hF0);
      rd(4'h8);
      wr(4'h0, $urandom & 32'hFF);
      rd(4'h0);
    end
    wr(4'h6, 32'h0);
    $display("test events done");
    uart_mode <= 1'h1;
    for (i = 0; i < 4; i++) begin
      frame_rx_data <= 8'($urandom);
      ev({8'($urandom), 3'h7});
      rd(4'hC);
      rd(4'h0);
      d = $urandom;
      wr(4'hC, d);
      rd(4'h0);
      chk("txdata", 32'(frame_tx_data), 32'(d[7:0]));
    end
    $display("test uart done");
    end_sim();
  end
endmodule
bind lsif_top lsif_assertions #(.ERR_W(ERR_W)) u_chk (.*);
`default_nettype wire
